// ==== inc/pmd_defs.vh ====
`ifndef PMD_DEFS_VH
`define PMD_DEFS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define PMD_IDX_FEEDBACK 16'hF000
`define PMD_IDX_PRESCALE 16'hF001
`define PMD_IDX_ENABLE   16'hF003
`define PMD_IDX_LOCK     16'hF004
`define PMD_IDX_STATUS   16'hF008
`define PMD_IDX_MASK     16'hF009
`define PMD_IDX_ACTIVE   16'hF00A

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PMD_FB_MSB       6
`define PMD_PRE_MSB      1
`define PMD_ENABLE_BIT   0
`define PMD_LOCK_BIT     0
`define PMD_EVT_GAIN     0
`define PMD_EVT_LOSS     1
`define PMD_ACT_PRE_LSB  8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define PMD_FB_RESET     7'h60
`define PMD_PRE_RESET    2'h0
`define PMD_STATUS_RESET 2'h0
`define PMD_MASK_RESET   2'h0

// ----------------------------------------------------------------
// prescale codes
// ----------------------------------------------------------------
`define PMD_PRE_DIV1     2'h0
`define PMD_PRE_DIV2     2'h1
`define PMD_PRE_DIV4     2'h2
`define PMD_PRE_DIV8     2'h3

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define PMD_CLOCK_MHZ     125
`define PMD_REF_TIMEOUT_NS 4000
`define PMD_REF_TIMEOUT_CYC ((`PMD_REF_TIMEOUT_NS * `PMD_CLOCK_MHZ) / 1000)
`define PMD_LOCK_REFS     16

`endif

// ==== core/pmd_prescaler.v ====
`include "pmd_defs.vh"
`default_nettype none

module pmd_prescaler (
  input  wire       clock,
  input  wire       rstN,
  input  wire       run,
  input  wire [1:0] divSel,
  input  wire       masterPin,
  output reg        refTick
);

  reg       pinPrev_q;
  reg [2:0] edgeCnt_q;

  // last edge count of one reference period for each code
  function [2:0] lastCount;
    input [1:0] code;
    begin
      case (code)
        `PMD_PRE_DIV1: lastCount = 3'h0;
        `PMD_PRE_DIV2: lastCount = 3'h1;
        `PMD_PRE_DIV4: lastCount = 3'h3;
        default:       lastCount = 3'h7;
      endcase
    end
  endfunction

  wire pinRise = masterPin & ~pinPrev_q;

  // count master clock rising edges, one reference tick per group
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      pinPrev_q <= 1'b0;
      edgeCnt_q <= 3'h0;
      refTick   <= 1'b0;
    end else begin
      pinPrev_q <= masterPin;
      refTick   <= 1'b0;
      if (!run) begin
        edgeCnt_q <= 3'h0; // idle while the multiplier is off
      end else if (pinRise) begin
        if (edgeCnt_q >= lastCount(divSel)) begin
          edgeCnt_q <= 3'h0;
          refTick   <= 1'b1;
        end else begin
          edgeCnt_q <= edgeCnt_q + 3'h1;
        end
      end
    end
  end

endmodule // pmd_prescaler

`default_nettype wire

// ==== core/pmd_freq_mult.v ====
`include "pmd_defs.vh"
`default_nettype none

module pmd_freq_mult #(
  parameter PERIOD_W  = 16,
  parameter LOCK_REFS = `PMD_LOCK_REFS,
  parameter TIMEOUT   = `PMD_REF_TIMEOUT_CYC
) (
  input  wire       clock,
  input  wire       rstN,
  input  wire       run,
  input  wire [6:0] fbValue,
  input  wire       refTick,
  output reg        sysTick,
  output reg        locked
);

  reg [PERIOD_W-1:0] periodCnt_q;
  reg [PERIOD_W-1:0] period_q;
  reg                periodOk_q;
  reg [7:0]          lockCnt_q;
  reg [PERIOD_W:0]   acc_q;

  wire [PERIOD_W:0] sum  = acc_q + {{(PERIOD_W-6){1'b0}}, fbValue};
  wire [PERIOD_W:0] left = sum - {1'b0, period_q};
  wire timedOut = (periodCnt_q >= TIMEOUT[PERIOD_W-1:0]);

  // measure the reference period and watch it for lock
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      periodCnt_q <= {PERIOD_W{1'b0}};
      period_q    <= {PERIOD_W{1'b0}};
      periodOk_q  <= 1'b0;
      lockCnt_q   <= 8'h00;
      locked      <= 1'b0;
    end else if (!run || fbValue == 7'h00 || timedOut) begin
      periodCnt_q <= {PERIOD_W{1'b0}};
      periodOk_q  <= 1'b0;
      lockCnt_q   <= 8'h00;
      locked      <= 1'b0;
    end else if (refTick) begin
      periodCnt_q <= {{(PERIOD_W-1){1'b0}}, 1'b1};
      period_q    <= periodCnt_q;
      periodOk_q  <= (periodCnt_q != {PERIOD_W{1'b0}});
      if (lockCnt_q >= LOCK_REFS[7:0]) begin
        locked <= 1'b1;
      end else begin
        lockCnt_q <= lockCnt_q + 8'h01;
      end
    end else begin
      periodCnt_q <= periodCnt_q + {{(PERIOD_W-1){1'b0}}, 1'b1};
    end
  end

  // rate accumulator: fbValue output ticks per reference period
  // limitation: at most one tick per clock, faster products saturate
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      acc_q   <= {(PERIOD_W+1){1'b0}};
      sysTick <= 1'b0;
    end else if (!run || !periodOk_q) begin
      acc_q   <= {(PERIOD_W+1){1'b0}};
      sysTick <= 1'b0;
    end else if (sum >= {1'b0, period_q}) begin
      sysTick <= 1'b1;
      acc_q   <= (left >= {1'b0, period_q}) ? {(PERIOD_W+1){1'b0}} : left;
    end else begin
      sysTick <= 1'b0;
      acc_q   <= sum;
    end
  end

endmodule // pmd_freq_mult

`default_nettype wire

// ==== core/pmd_pll_config.v ====
`include "pmd_defs.vh"
`default_nettype none

// ----------------------------------------------------------------
// clock multiplier configuration block
// ----------------------------------------------------------------

// Contract
// - feedback divider is seven-bit whole number
// - output rate is reference times feedback; the code gives at most one tick per clock and saturates above that
// - feedback divider resets to 0x60
// - staged values apply on enable rising
// - prescale 00 divides one, 01 two
// - prescale register resets to zero
// - no output clock while disabled
// - read-only lock flag after stable output
module pmd_pll_config #(
  parameter PERIOD_W  = 16,
  parameter LOCK_REFS = `PMD_LOCK_REFS,
  parameter TIMEOUT   = `PMD_REF_TIMEOUT_CYC
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [17:0] avsAddress,
  input  wire        avsRead,
  input  wire        avsWrite,
  input  wire [31:0] avsWriteData,
  input  wire [3:0]  avsByteEnable,
  output reg  [31:0] avsReadData,
  output wire        avsWaitRequest,
  input  wire        masterClockInputPin,
  output wire        sysClkEn,
  output wire        pllLocked,
  output reg  [6:0]  feedbackMultiplyValue,
  output reg  [1:0]  prescaleActive,
  output reg         irq
);

  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------

  reg  [1:0] rstSync_q;
  wire       rstN;

  // assert at once, release after two clean edges
  always @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      rstSync_q <= 2'b00;
    end else begin
      rstSync_q <= {rstSync_q[0], 1'b1};
    end
  end

  assign rstN = rstSync_q[1];

  // ----------------------------------------------------------------
  // bus slave
  // ----------------------------------------------------------------

  reg         busAck_q;
  wire        busReq;
  wire        wrAcc;
  wire        wrLow;
  wire        rdFirst;
  wire [15:0] regIdx;
  reg  [31:0] rdMux;

  // true when the word index selects the given register
  function hit;
    input [15:0] idx;
    input [15:0] target;
    begin
      hit = (idx == target);
    end
  endfunction

  assign busReq  = avsRead | avsWrite;
  assign regIdx  = avsAddress[17:2];
  assign rdFirst = avsRead & ~busAck_q;
  assign wrAcc   = avsWrite & busAck_q;
  assign wrLow   = wrAcc & avsByteEnable[0]; // all writable fields sit in byte 0

  // one wait cycle per access: read data is settled before release
  assign avsWaitRequest = busReq & ~busAck_q;

  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      busAck_q <= 1'b0;
    end else begin
      busAck_q <= busReq & ~busAck_q;
    end
  end

  // ----------------------------------------------------------------
  // staged configuration
  // ----------------------------------------------------------------

  reg [6:0] fbStage_q;
  reg [1:0] preStage_q;
  reg       enable_q;
  reg       enablePrev_q;
  reg       run_q;
  wire      applyNow;

  // software side copies; these never reach the multiplier directly
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      fbStage_q  <= `PMD_FB_RESET;
      preStage_q <= `PMD_PRE_RESET;
      enable_q   <= 1'b0;
    end else if (wrLow) begin
      if (hit(regIdx, `PMD_IDX_FEEDBACK)) begin
        fbStage_q <= avsWriteData[`PMD_FB_MSB:0];
      end
      if (hit(regIdx, `PMD_IDX_PRESCALE)) begin
        preStage_q <= avsWriteData[`PMD_PRE_MSB:0];
      end
      if (hit(regIdx, `PMD_IDX_ENABLE)) begin
        enable_q <= avsWriteData[`PMD_ENABLE_BIT];
      end
    end
  end

  assign applyNow = enable_q & ~enablePrev_q;

  // only a zero-to-one step of the enable loads the active copies;
  // rewriting one while already enabled changes nothing
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      enablePrev_q          <= 1'b0;
      run_q                 <= 1'b0;
      feedbackMultiplyValue <= `PMD_FB_RESET;
      prescaleActive        <= `PMD_PRE_RESET;
    end else begin
      enablePrev_q <= enable_q;
      run_q        <= enable_q;
      if (applyNow) begin
        feedbackMultiplyValue <= fbStage_q;
        prescaleActive        <= preStage_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // reference divider and multiplier
  // ----------------------------------------------------------------

  wire refTick;

  pmd_prescaler u_prescaler (
    .clock     (clock),
    .rstN      (rstN),
    .run       (run_q),
    .divSel    (prescaleActive),
    .masterPin (masterClockInputPin),
    .refTick   (refTick)
  );

  pmd_freq_mult #(
    .PERIOD_W  (PERIOD_W),
    .LOCK_REFS (LOCK_REFS),
    .TIMEOUT   (TIMEOUT)
  ) u_freq_mult (
    .clock   (clock),
    .rstN    (rstN),
    .run     (run_q),
    .fbValue (feedbackMultiplyValue),
    .refTick (refTick),
    .sysTick (sysClkEn),
    .locked  (pllLocked)
  );

  // ----------------------------------------------------------------
  // lock events and interrupt
  // ----------------------------------------------------------------

  reg  [1:0] status_q;
  reg  [1:0] mask_q;
  reg        lockPrev_q;
  wire [1:0] events;
  wire [1:0] clearBits;

  assign events[`PMD_EVT_GAIN] = pllLocked & ~lockPrev_q;
  assign events[`PMD_EVT_LOSS] = ~pllLocked & lockPrev_q;

  assign clearBits = (wrLow && hit(regIdx, `PMD_IDX_STATUS)) ?
                     avsWriteData[1:0] : 2'b00;

  // write one to clear; a new event in the same cycle wins
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      lockPrev_q <= 1'b0;
      status_q   <= `PMD_STATUS_RESET;
      mask_q     <= `PMD_MASK_RESET;
      irq        <= 1'b0;
    end else begin
      lockPrev_q <= pllLocked;
      status_q   <= (status_q & ~clearBits) | events;
      if (wrLow && hit(regIdx, `PMD_IDX_MASK)) begin
        mask_q <= avsWriteData[1:0];
      end
      irq <= |(status_q & mask_q);
    end
  end

  // ----------------------------------------------------------------
  // read path
  // ----------------------------------------------------------------

  // unmapped indices read as zero, reserved bits likewise
  always @* begin
    rdMux = 32'h0000_0000;
    case (regIdx)
      `PMD_IDX_FEEDBACK: rdMux[`PMD_FB_MSB:0]  = fbStage_q;
      `PMD_IDX_PRESCALE: rdMux[`PMD_PRE_MSB:0] = preStage_q;
      `PMD_IDX_ENABLE:   rdMux[`PMD_ENABLE_BIT] = enable_q;
      `PMD_IDX_LOCK:     rdMux[`PMD_LOCK_BIT]   = pllLocked;
      `PMD_IDX_STATUS:   rdMux[1:0] = status_q;
      `PMD_IDX_MASK:     rdMux[1:0] = mask_q;
      `PMD_IDX_ACTIVE: begin
        rdMux[`PMD_FB_MSB:0] = feedbackMultiplyValue;
        rdMux[`PMD_ACT_PRE_LSB+1:`PMD_ACT_PRE_LSB] = prescaleActive;
      end
      default:           rdMux = 32'h0000_0000;
    endcase
  end

  // latched in the wait cycle, held until the next read
  always @(posedge clock or negedge rstN) begin
    if (!rstN) begin
      avsReadData <= 32'h0000_0000;
    end else if (rdFirst) begin
      avsReadData <= rdMux;
    end
  end

endmodule // pmd_pll_config

`default_nettype wire

// ==== tb/pmd_pll_checker.sv ====
`default_nettype none
module pmd_pll_checker (
  input wire logic        clock,
  input wire logic        rst_n,
  input wire logic [17:0] avsAddress,
  input wire logic        avsRead,
  input wire logic        avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0]  avsByteEnable,
  input wire logic [31:0] avsReadData,
  input wire logic        avsWaitRequest,
  input wire logic        masterClockInputPin,
  input wire logic        sysClkEn,
  input wire logic        pllLocked,
  input wire logic [6:0]  feedbackMultiplyValue,
  input wire logic [1:0]  prescaleActive,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ps;
  // ----
  // helpers
  // ----
  logic        req;
  logic        done;
  logic        enWr;
  logic        rdDone;
  logic [15:0] idx;
  logic        enOn_q;
  assign req = avsRead | avsWrite;
  assign done = req & ~avsWaitRequest;
  assign rdDone = done & avsRead;
  assign idx = avsAddress[17:2];
  assign enWr = done & avsWrite & (idx == 16'hF003) & avsByteEnable[0] & avsWriteData[0];
  // enable bit as software last wrote it; the design lags this by a few cycles
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) enOn_q <= 1'b0;
    else if (done & avsWrite & (idx == 16'hF003) & avsByteEnable[0]) enOn_q <= avsWriteData[0];
  end
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ----
  // properties
  // ----
  wait_first_a: assert property (req && !$past(req) |-> avsWaitRequest)
    else $error("no wait state in first request cycle");
  wait_one_a: assert property (req && avsWaitRequest |=> !avsWaitRequest)
    else $error("more than one wait state");
  reset_vals_a: assert property ($rose(rst_n) |-> feedbackMultiplyValue == 7'h60 && prescaleActive == 2'h0)
    else $error("applied values wrong out of reset");
  apply_on_en_a: assert property ($changed(feedbackMultiplyValue) || $changed(prescaleActive)
    |-> $past(enWr) || $past(enWr, 2) || $past(enWr, 3))
    else $error("applied value changed without enable rising");
  fb_width_a: assert property (rdDone && idx == 16'hF000 |-> avsReadData[31:7] == 25'h0)
    else $error("feedback read wider than seven bits");
  pre_width_a: assert property (rdDone && idx == 16'hF001 |-> avsReadData[31:2] == 30'h0)
    else $error("prescale read wider than two bits");
  lock_read_a: assert property (rdDone && idx == 16'hF004 |-> avsReadData == {31'h0, $past(pllLocked)})
    else $error("lock register differs from lock flag");
  lock_fb_a: assert property ($rose(pllLocked) |-> feedbackMultiplyValue != 7'h00)
    else $error("lock with zero feedback");
  idle_off_a: assert property (sysClkEn |-> enOn_q || $past(enOn_q) || $past(enOn_q, 2)
    || $past(enOn_q, 3) || $past(enOn_q, 4))
    else $error("clock enable while disabled");
  cover property ($rose(pllLocked));
  cover property ($rose(irq));
  cover property (enWr);
  cover property (sysClkEn);
endmodule // pmd_pll_checker

bind pmd_pll_config pmd_pll_checker u_pmd_pll_checker (
  .clock(clock), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
  .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
  .masterClockInputPin(masterClockInputPin), .sysClkEn(sysClkEn), .pllLocked(pllLocked),
  .feedbackMultiplyValue(feedbackMultiplyValue), .prescaleActive(prescaleActive), .irq(irq));
`default_nettype wire

// ==== tb/tb_top.sv ====
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock, rst_n, avsRead, avsWrite, masterClockInputPin;
  logic        avsWaitRequest, sysClkEn, pllLocked, irq;
  logic [17:0] avsAddress;
  logic [31:0] avsWriteData, avsReadData, rdData;
  logic [3:0]  avsByteEnable;
  logic [6:0]  feedbackMultiplyValue;
  logic [1:0]  prescaleActive;
  logic [2:0]  pinCnt;
  int          fail_count, checks_done, tickCount, startCnt, n;

  // short lock count keeps each relock to a few reference ticks
  pmd_pll_config #(.LOCK_REFS(2)) u_pmd_pll_config (
    .clock(clock), .rst_n(rst_n), .avsAddress(avsAddress), .avsRead(avsRead),
    .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
    .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest),
    .masterClockInputPin(masterClockInputPin), .sysClkEn(sysClkEn), .pllLocked(pllLocked),
    .feedbackMultiplyValue(feedbackMultiplyValue), .prescaleActive(prescaleActive), .irq(irq));

  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  // master pin period of four clocks, safely below half the clock rate
  always @(posedge clock) begin
    pinCnt <= pinCnt + 3'h1;
    masterClockInputPin <= pinCnt[1];
    if (sysClkEn === 1'b1) tickCount <= tickCount + 1;
  end
  // ----
  // bus and compare tasks
  // ----
  task automatic bus(input logic wr, input logic [15:0] idx, input logic [31:0] d,
                     input logic [3:0] be);
    int k;
    @(posedge clock);
    avsAddress <= {idx, 2'b00};
    avsWrite <= wr;
    avsRead <= !wr;
    avsWriteData <= d;
    avsByteEnable <= be;
    k = 0;
    // sample waitrequest at each rising edge; data taken at the same edge
    do begin
      @(posedge clock);
      k++;
    end while (avsWaitRequest !== 1'b0 && k < 100);
    if (avsWaitRequest !== 1'b0) begin
      fail_count++;
      $display("[ERR] %0t bus hang", $time);
    end
    rdData = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic checkEq(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, exp);
    end
  endtask
  task automatic checkNear(input int got, input int exp, input int tol);
    checks_done++;
    if (got < exp - tol || got > exp + tol) begin
      fail_count++;
      $display("[ERR] %0t count %0d want %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    bus(1'b1, idx, d, 4'hF);
  endtask
  task automatic rdChk(input logic [15:0] idx, input logic [31:0] exp);
    bus(1'b0, idx, 32'h0, 4'hF);
    checkEq(rdData, exp);
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // ----
  // watchdog and tests
  // ----
  initial begin
    #400000;
    fail_count++;
    $display("[ERR] %0t timeout", $time);
    print_verdict();
  end
  initial begin
    {rst_n, avsRead, avsWrite, masterClockInputPin} = 4'h0;
    {avsAddress, avsWriteData, avsByteEnable, pinCnt} = '0;
    {fail_count, checks_done, tickCount} = '0;
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    repeat (4) @(posedge clock);
    rdChk(16'hF000, 32'h60);
    rdChk(16'hF001, 32'h0);
    rdChk(16'hF00A, 32'h60);
    checkEq({25'h0, feedbackMultiplyValue}, 32'h60);
    wr(16'hF000, 32'hFFFFFFFF);
    rdChk(16'hF000, 32'h7F);
    wr(16'hF001, 32'hFFFFFFFF);
    rdChk(16'hF001, 32'h3);
    bus(1'b1, 16'hF000, 32'h5, 4'h0);
    rdChk(16'hF000, 32'h7F);
    rdChk(16'hF00F, 32'h0);
    wr(16'hF004, 32'h1);
    rdChk(16'hF004, 32'h0);
    rdChk(16'hF00A, 32'h60);
    checkNear(tickCount, 0, 0);
    wr(16'hF009, 32'h1);
    // every prescale code; rate is fb / (4 * divide) ticks per clock
    for (int c = 0; c < 4; c++) begin
      wr(16'hF003, 32'h0);
      wr(16'hF001, c);
      wr(16'hF000, 32'h2);
      wr(16'hF003, 32'h1);
      rdChk(16'hF00A, (c << 8) | 2);
      n = 0;
      while (pllLocked !== 1'b1 && n < 3000) begin
        @(negedge clock);
        n++;
      end
      checkEq({31'h0, pllLocked}, 32'h1);
      startCnt = tickCount;
      repeat (512) @(posedge clock);
      checkNear(tickCount - startCnt, 256 >> c, 3);
    end
    checkEq({31'h0, irq}, 32'h1);
    rdChk(16'hF008, 32'h3);
    wr(16'hF008, 32'h1);
    repeat (3) @(posedge clock);
    checkEq({31'h0, irq}, 32'h0);
    rdChk(16'hF008, 32'h2);
    // a second enable write while running must not apply the new feedback
    wr(16'hF000, 32'h5);
    wr(16'hF003, 32'h1);
    rdChk(16'hF00A, 32'h302);
    wr(16'hF003, 32'h0);
    repeat (4) @(posedge clock);
    checkEq({31'h0, pllLocked}, 32'h0);
    startCnt = tickCount;
    repeat (100) @(posedge clock);
    checkNear(tickCount - startCnt, 0, 0);
    print_verdict();
  end
endmodule // tb_top
`default_nettype wire
